// ---- hw/udma_pkg.sv ----
// constants, mode timing and crc for the ultra dma data-in burst
package udma_pkg;
    localparam int WORD_W = 16;
    localparam int MODE_W = 2;
    localparam int CNT_W = 8;
    localparam int MODES = 3;
    localparam int LINK_NS = 80;
    localparam int CLK_NS = 40;
    // link clock half period in host clocks
    localparam int LINK_HALF = LINK_NS / (2 * CLK_NS);
    // mode tables: cycle time, data setup, data hold
    localparam int T_CYC_NS [MODES] = '{480, 320, 240};
    localparam int T_DVS_NS [MODES] = '{160, 160, 80};
    localparam int T_DVH_NS [MODES] = '{160, 160, 160};
    localparam int T_ZIO_NS = 80;
    localparam int T_ZAD_NS = 80;
    localparam int T_SS_NS = 160;
    localparam int T_ACK_NS = 320;
    localparam int T_RP_NS = 480;
    localparam int T_ZAH_NS = 160;
    localparam int T_MLI_NS = 320;
    localparam logic [WORD_W-1:0] CRC_SEED = 16'hFFFF;
    localparam logic [WORD_W-1:0] CRC_POLY = 16'h1021;

    function automatic int at_least(input int ns, input int per);
        int c;
        c = (ns + per - 1) / per;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic logic [CNT_W-1:0] link_count(input int ns);
        return CNT_W'(at_least(ns, LINK_NS));
    endfunction

    function automatic logic [CNT_W-1:0] clk_count(input int ns);
        return CNT_W'(at_least(ns, CLK_NS));
    endfunction

    localparam logic [CNT_W-1:0] ZIO_CNT = link_count(T_ZIO_NS);
    localparam logic [CNT_W-1:0] ZAD_CNT = link_count(T_ZAD_NS);
    localparam logic [CNT_W-1:0] SS_CNT = link_count(T_SS_NS);
    localparam logic [CNT_W-1:0] ACK_CNT = clk_count(T_ACK_NS);
    localparam logic [CNT_W-1:0] RP_CNT = clk_count(T_RP_NS);
    localparam logic [CNT_W-1:0] ZAH_CNT = clk_count(T_ZAH_NS);
    localparam logic [CNT_W-1:0] MLI_CNT = clk_count(T_MLI_NS);

    function automatic logic [WORD_W-1:0] crc_step(
        input logic [WORD_W-1:0] c,
        input logic [WORD_W-1:0] w
    );
        logic [WORD_W-1:0] r;
        r = c;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            r = {r[WORD_W-2:0], 1'b0} ^ ((r[WORD_W-1] ^ w[i]) ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction
endpackage

// ---- hw/udma_if.sv ----
// wires of the burst link between host and device
`timescale 1ns/1ps
interface udma_if;
    import udma_pkg::*;
    logic link_clk;
    logic dmarq;
    logic dmack_n;
    logic stop;
    logic hdmardy_n;
    logic addr_idle;
    logic dstrobe_o;
    logic dstrobe_oe_n;
    logic [WORD_W-1:0] dd_dev_o;
    logic dd_dev_oe_n;
    logic [WORD_W-1:0] dd_host_o;
    logic dd_host_oe_n;
    logic dstrobe;
    logic [WORD_W-1:0] dd;

    // released strobe floats high, released data bus reads zero
    assign dstrobe = !dstrobe_oe_n ? dstrobe_o : 1'b1;
    assign dd = !dd_dev_oe_n ? dd_dev_o : (!dd_host_oe_n ? dd_host_o : 16'h0000);

    modport device(
        input link_clk, dmack_n, stop, hdmardy_n, addr_idle, dd,
        output dmarq, dstrobe_o, dstrobe_oe_n, dd_dev_o, dd_dev_oe_n
    );
    modport host(
        output link_clk, dmack_n, stop, hdmardy_n, addr_idle, dd_host_o, dd_host_oe_n,
        input dmarq, dstrobe, dd
    );
endinterface

// ---- hw/udma_sync.sv ----
// two-stage synchroniser for a group of link signals
`timescale 1ns/1ps
module udma_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // signals
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_type;

    sync_type s;
    sync_type next_s;

    always_comb begin
        next_s.first = d;
        next_s.second = s.first;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= {RESET_VAL, RESET_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign q = s.second;
endmodule

// ---- hw/udma_device.sv ----
// device end: requests a data-in burst and streams words out
`timescale 1ns/1ps
module udma_device (
    // reset, clock comes from the link
    input wire logic rst,
    // link
    udma_if.device bus,
    // command
    input wire logic [udma_pkg::MODE_W-1:0] mode,
    input wire logic start,
    input wire logic [udma_pkg::WORD_W-1:0] count,
    // word source
    input wire logic [udma_pkg::WORD_W-1:0] word,
    input wire logic word_valid,
    output logic word_ready,
    // status
    output logic busy,
    output logic done,
    output logic crc_error
);
    import udma_pkg::*;

    typedef enum logic [2:0] {
        D_IDLE,
        D_REQ,
        D_ENABLE,
        D_TURN,
        D_XFER,
        D_TERM
    } dev_state_type;

    typedef struct packed {
        dev_state_type state;
        logic [MODE_W-1:0] mode;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] age;
        logic [WORD_W-1:0] left;
        logic [WORD_W-1:0] crc;
        logic [WORD_W-1:0] dd;
        logic dd_en;
        logic strobe;
        logic strobe_en;
        logic dmarq;
        logic loaded;
        logic sent_any;
        logic ack_q;
        logic done;
        logic crc_error;
    } dev_type;

    dev_type s;
    dev_type next_s;

    localparam logic [WORD_W+2:0] SYNC_RESET = {3'b111, 16'h0000};

    logic [WORD_W+2:0] synced;
    logic ack_n;
    logic stop_s;
    logic rdy_n;
    logic [WORD_W-1:0] dd_s;
    logic ready;
    logic load;
    logic toggle;
    logic [CNT_W-1:0] cyc_n;
    logic [CNT_W-1:0] dvs_n;
    logic [CNT_W-1:0] dvh_n;
    logic [MODE_W-1:0] m;

    // ----------------------------------------------------------------
    // link inputs
    // ----------------------------------------------------------------
    // data bus rides along so the crc is sampled aligned with grant
    udma_sync #(
        .WIDTH(WORD_W + 3),
        .RESET_VAL(SYNC_RESET)
    ) u_sync (
        .clk(bus.link_clk),
        .rst(rst),
        .d({bus.dmack_n, bus.stop, bus.hdmardy_n, bus.dd}),
        .q(synced)
    );

    assign ack_n = synced[WORD_W+2];
    assign stop_s = synced[WORD_W+1];
    assign rdy_n = synced[WORD_W];
    assign dd_s = synced[WORD_W-1:0];

    // ----------------------------------------------------------------
    // mode timing
    // ----------------------------------------------------------------
    always_comb begin
        m = (int'(s.mode) < MODES) ? s.mode : '0;
        cyc_n = link_count(T_CYC_NS[m]);
        dvs_n = link_count(T_DVS_NS[m]);
        dvh_n = link_count(T_DVH_NS[m]);
    end

    assign ready = !stop_s && !rdy_n;
    // no edge before the loaded word has met its setup time
    assign toggle = (s.state == D_XFER) && s.loaded && ready && (s.cnt >= cyc_n)
        && (s.age >= dvs_n) && !(stop_s && s.sent_any);
    // next word waits out the hold time of the last edge
    assign load = (s.state == D_XFER) && !s.loaded && (s.left != '0)
        && (s.cnt >= dvh_n) && word_valid && !(stop_s && s.sent_any);
    assign word_ready = load;

    // ----------------------------------------------------------------
    // burst state machine
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.ack_q = ack_n;
        if (s.cnt != 8'hFF) begin
            next_s.cnt = s.cnt + 8'h01;
        end
        if (s.age != 8'hFF) begin
            next_s.age = s.age + 8'h01;
        end
        case (s.state)
            D_IDLE: begin
                if (start && count != '0) begin
                    next_s.dmarq = 1'b1;
                    next_s.mode = mode;
                    next_s.left = count;
                    next_s.crc = CRC_SEED;
                    next_s.sent_any = 1'b0;
                    next_s.loaded = 1'b0;
                    next_s.crc_error = 1'b0;
                    next_s.state = D_REQ;
                end
            end
            D_REQ: begin
                next_s.cnt = '0;
                if (!ack_n) begin
                    next_s.state = D_ENABLE;
                end
            end
            D_ENABLE: begin
                if (s.cnt >= ZIO_CNT) begin
                    next_s.strobe_en = 1'b1;
                    next_s.strobe = 1'b1;
                    next_s.cnt = '0;
                    next_s.state = D_TURN;
                end
            end
            D_TURN: begin
                if (!ready) begin
                    next_s.cnt = '0;
                end else if (s.cnt >= ZAD_CNT) begin
                    next_s.dd_en = 1'b1;
                    next_s.cnt = 8'hFF;
                    next_s.age = '0;
                    next_s.state = D_XFER;
                end
            end
            D_XFER: begin
                if (stop_s && s.sent_any) begin
                    // host ends the burst: let go of request and bus
                    next_s.dmarq = 1'b0;
                    next_s.dd_en = 1'b0;
                    next_s.strobe = 1'b1;
                    next_s.state = D_TERM;
                end else if (toggle) begin
                    next_s.strobe = !s.strobe;
                    next_s.cnt = '0;
                    next_s.loaded = 1'b0;
                    next_s.sent_any = 1'b1;
                    next_s.crc = crc_step(s.crc, s.dd);
                end else if (load) begin
                    next_s.dd = word;
                    next_s.loaded = 1'b1;
                    next_s.age = '0;
                    next_s.left = s.left - 16'h0001;
                end else if (!s.loaded && s.left == '0 && s.cnt >= SS_CNT) begin
                    // all words sent: device ends the burst
                    next_s.dmarq = 1'b0;
                    next_s.dd_en = 1'b0;
                    next_s.state = D_TERM;
                end
            end
            D_TERM: begin
                if (stop_s) begin
                    next_s.strobe = 1'b1;
                end
                if (!s.ack_q && ack_n) begin
                    // first miscompare of the command stays
                    next_s.crc_error = s.crc_error | (dd_s != s.crc);
                    next_s.strobe_en = 1'b0;
                    next_s.done = 1'b1;
                    next_s.state = D_IDLE;
                end
            end
            default: begin
                next_s.state = D_IDLE;
            end
        endcase
    end

    always_ff @(posedge bus.link_clk or posedge rst) begin
        if (rst) begin
            s <= '{state: D_IDLE, ack_q: 1'b1, strobe: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bus.dmarq = s.dmarq;
    assign bus.dstrobe_o = s.strobe;
    assign bus.dstrobe_oe_n = !s.strobe_en;
    assign bus.dd_dev_o = s.dd;
    assign bus.dd_dev_oe_n = !s.dd_en;
    assign busy = (s.state != D_IDLE);
    assign done = s.done;
    assign crc_error = s.crc_error;
endmodule

// ---- hw/udma_host.sv ----
// host end: grants data-in bursts, collects words, returns the crc
`timescale 1ns/1ps
module udma_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    udma_if.host bus,
    // control
    input wire logic enable,
    input wire logic hold,
    input wire logic terminate,
    // received words
    output logic [udma_pkg::WORD_W-1:0] word,
    output logic word_valid,
    // status
    output logic busy,
    output logic burst_done
);
    import udma_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE,
        H_SETUP,
        H_GRANT,
        H_RUN,
        H_STOPPING,
        H_ENDWAIT,
        H_CRC,
        H_RELEASE
    } host_state_type;

    typedef struct packed {
        host_state_type state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] div;
        logic lclk;
        logic dmack_n;
        logic stop;
        logic hdmardy_n;
        logic addr_idle;
        logic dd_oe_n;
        logic st_q;
        logic got_any;
        logic [WORD_W-1:0] crc;
        logic [WORD_W-1:0] word;
        logic word_valid;
        logic done;
    } host_type;

    host_type s;
    host_type next_s;

    localparam logic [WORD_W+1:0] SYNC_RESET = {2'b01, 16'h0000};

    logic [WORD_W+1:0] synced;
    logic rq;
    logic ds;
    logic [WORD_W-1:0] dd_s;
    logic edge_seen;

    // data rides with the strobe so a word is aligned with its edge
    udma_sync #(
        .WIDTH(WORD_W + 2),
        .RESET_VAL(SYNC_RESET)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d({bus.dmarq, bus.dstrobe, bus.dd}),
        .q(synced)
    );

    assign rq = synced[WORD_W+1];
    assign ds = synced[WORD_W];
    assign dd_s = synced[WORD_W-1:0];
    assign edge_seen = (ds != s.st_q);

    // ----------------------------------------------------------------
    // grant state machine
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.word_valid = 1'b0;
        next_s.done = 1'b0;
        next_s.st_q = ds;
        next_s.cnt = s.cnt + 8'h01;
        next_s.div = s.div + 8'h01;
        if (int'(s.div) >= LINK_HALF - 1) begin
            next_s.div = '0;
            next_s.lclk = !s.lclk;
        end
        if ((s.state == H_RUN || s.state == H_STOPPING) && edge_seen) begin
            next_s.word = dd_s;
            next_s.word_valid = 1'b1;
            next_s.got_any = 1'b1;
            next_s.crc = crc_step(s.crc, dd_s);
        end
        case (s.state)
            H_IDLE: begin
                next_s.cnt = '0;
                next_s.dmack_n = 1'b1;
                if (enable && rq) begin
                    next_s.stop = 1'b1;
                    next_s.hdmardy_n = 1'b1;
                    next_s.addr_idle = 1'b1;
                    next_s.crc = CRC_SEED;
                    next_s.got_any = 1'b0;
                    next_s.state = H_SETUP;
                end
            end
            H_SETUP: begin
                if (s.cnt >= ACK_CNT) begin
                    next_s.dmack_n = 1'b0;
                    next_s.dd_oe_n = 1'b1;
                    next_s.state = H_GRANT;
                end
            end
            H_GRANT: begin
                next_s.stop = 1'b0;
                next_s.hdmardy_n = 1'b0;
                next_s.state = H_RUN;
            end
            H_RUN: begin
                next_s.cnt = '0;
                if (!rq) begin
                    next_s.stop = 1'b1;
                    next_s.hdmardy_n = 1'b1;
                    next_s.state = H_ENDWAIT;
                end else if (terminate && s.got_any) begin
                    next_s.hdmardy_n = 1'b1;
                    next_s.state = H_STOPPING;
                end else begin
                    // no pause before the first word arrives
                    next_s.hdmardy_n = hold && s.got_any;
                end
            end
            H_STOPPING: begin
                if (s.cnt >= RP_CNT) begin
                    next_s.stop = 1'b1;
                    next_s.state = H_ENDWAIT;
                end
            end
            H_ENDWAIT: begin
                if (rq || !ds) begin
                    next_s.cnt = '0;
                end else if (s.cnt >= ZAH_CNT) begin
                    next_s.dd_oe_n = 1'b0;
                    next_s.cnt = '0;
                    next_s.state = H_CRC;
                end
            end
            H_CRC: begin
                if (s.cnt >= MLI_CNT) begin
                    next_s.dmack_n = 1'b1;
                    next_s.cnt = '0;
                    next_s.done = 1'b1;
                    next_s.state = H_RELEASE;
                end
            end
            H_RELEASE: begin
                // crc stays on the bus until the device has seen grant drop
                if (s.cnt >= ACK_CNT) begin
                    next_s.dd_oe_n = 1'b1;
                    next_s.addr_idle = 1'b0;
                    next_s.state = H_IDLE;
                end
            end
            default: begin
                next_s.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '{state: H_IDLE, dmack_n: 1'b1, stop: 1'b1, hdmardy_n: 1'b1,
                dd_oe_n: 1'b1, st_q: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign bus.link_clk = s.lclk;
    assign bus.dmack_n = s.dmack_n;
    assign bus.stop = s.stop;
    assign bus.hdmardy_n = s.hdmardy_n;
    assign bus.addr_idle = s.addr_idle;
    assign bus.dd_host_o = s.crc;
    assign bus.dd_host_oe_n = s.dd_oe_n;
    assign word = s.word;
    assign word_valid = s.word_valid;
    assign busy = (s.state != H_IDLE);
    assign burst_done = s.done;
endmodule

// ---- tb/udma_sva.sv ----
// assertions on the burst link between host and device
`timescale 1ns/1ps
module udma_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic dmarq,
    input wire logic dmack_n,
    input wire logic stop,
    input wire logic hdmardy_n,
    input wire logic addr_idle,
    input wire logic dstrobe_oe_n,
    input wire logic dstrobe,
    input wire logic dd_dev_oe_n,
    input wire logic dd_host_oe_n,
    input wire logic [udma_pkg::WORD_W-1:0] dd
);
    import udma_pkg::*;
    // ----------------------------------------
    // helpers, limits in host clocks
    // ----------------------------------------
    // fastest mode gives the loosest floor, mode is not visible here
    localparam int DVS_MIN = 2 * link_count(T_DVS_NS[MODES-1]);
    localparam int CYC_MIN = 2 * link_count(T_CYC_NS[MODES-1]);
    // two sync stages plus a word already in flight
    localparam int RFS_MAX = 16;
    logic prev_strobe;
    logic [WORD_W-1:0] prev_dd;
    logic [7:0] toggles;
    logic [7:0] setup_age;
    logic [7:0] ready_age;
    logic [7:0] dd_age;
    logic [7:0] tog_age;
    logic [7:0] off_age;
    wire edge_seen = dstrobe != prev_strobe;
    wire tog = edge_seen && !stop;
    wire rdy = !dmack_n && !stop && !hdmardy_n;
    function automatic logic [7:0] inc(input logic [7:0] v);
        return v + {7'h00, v != 8'hFF};
    endfunction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_strobe <= 1'b1;
            prev_dd <= '0;
            toggles <= 8'h00;
            setup_age <= 8'h00;
            ready_age <= 8'h00;
            dd_age <= 8'h00;
            tog_age <= 8'hFF;
            off_age <= 8'h00;
        end else begin
            prev_strobe <= dstrobe;
            prev_dd <= dd;
            toggles <= dmack_n ? 8'h00 : (tog ? inc(toggles) : toggles);
            setup_age <= (stop && hdmardy_n && addr_idle) ? inc(setup_age) : 8'h00;
            ready_age <= rdy ? inc(ready_age) : 8'h00;
            dd_age <= (dd != prev_dd) ? 8'h01 : inc(dd_age);
            tog_age <= edge_seen ? 8'h01 : inc(tog_age);
            off_age <= (!dmack_n && hdmardy_n) ? inc(off_age) : 8'h00;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_grant_req; $fell(dmack_n) |-> dmarq; endproperty
    a_grant_req: assert property (p_grant_req) else $error("grant without request");
    property p_req_hold; $fell(dmarq) |-> toggles != 8'h00; endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    property p_setup; $fell(dmack_n) |-> setup_age >= ACK_CNT; endproperty
    a_setup: assert property (p_setup) else $error("grant setup short");
    property p_addr; (!dmack_n || $rose(dmack_n)) |-> addr_idle; endproperty
    a_addr: assert property (p_addr) else $error("address active in burst");
    property p_bus_own; !dd_dev_oe_n |-> dd_host_oe_n && !dmack_n; endproperty
    a_bus_own: assert property (p_bus_own) else $error("data bus contention");
    property p_strobe; !dmack_n && !dstrobe_oe_n |=> !dstrobe_oe_n; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe released in burst");
    property p_ready; $fell(dmack_n) |-> ##[1:2] (!stop && !hdmardy_n); endproperty
    a_ready: assert property (p_ready) else $error("ready late after grant");
    property p_first; rdy && toggles == 8'h00 |=> !stop && !hdmardy_n; endproperty
    a_first: assert property (p_first) else $error("ready changed before word");
    property p_turn; $fell(dd_dev_oe_n) |-> rdy && ready_age >= 2 * ZAD_CNT; endproperty
    a_turn: assert property (p_turn) else $error("data driven too soon");
    property p_dvs; tog |-> dd_age >= DVS_MIN; endproperty
    a_dvs: assert property (p_dvs) else $error("data setup short");
    property p_cyc; tog |-> tog_age >= CYC_MIN; endproperty
    a_cyc: assert property (p_cyc) else $error("strobe edges too close");
    property p_dvh; tog |=> $stable(dd) [*3]; endproperty
    a_dvh: assert property (p_dvh) else $error("data hold short");
    property p_rfs; tog |-> off_age < RFS_MAX; endproperty
    a_rfs: assert property (p_rfs) else $error("strobe after ready off");
    c_first: cover property (tog && toggles == 8'h00);
    c_pause: cover property ($rose(hdmardy_n) && !dmack_n && !stop);
    c_end: cover property ($rose(dmack_n));
endmodule

// ---- tb/tb_ultra_dma_data_in_burst.sv ----
// self-checking bench joining host and device ends of the burst link
`timescale 1ns/1ps
module tb_ultra_dma_data_in_burst;
    import udma_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int MAXW = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [MODE_W-1:0] mode = '0;
    logic start = 1'b0;
    logic [WORD_W-1:0] count = '0;
    logic [WORD_W-1:0] src_word;
    logic src_valid = 1'b1;
    logic src_ready, dev_busy, dev_done, crc_error;
    logic enable = 1'b0;
    logic hold = 1'b0;
    logic terminate = 1'b0;
    logic [WORD_W-1:0] rx_word;
    logic rx_valid, host_busy, burst_done, took;
    logic [WORD_W-1:0] src [MAXW];
    int src_idx = 0, rx_idx = 0, hold_at = -1, stall_at = -1, hold_len = 0, stall_len = 0;
    int n_bursts = 0, err_count = 0, checks_done = 0;
    // ----------------------------------------
    // design and checker
    // ----------------------------------------
    udma_if bus();
    udma_device i_udma_device(.rst(rst), .bus(bus), .mode(mode), .start(start),
        .count(count), .word(src_word), .word_valid(src_valid), .word_ready(src_ready),
        .busy(dev_busy), .done(dev_done), .crc_error(crc_error));
    udma_host i_udma_host(.clk(clk), .rst(rst), .bus(bus), .enable(enable), .hold(hold),
        .terminate(terminate), .word(rx_word), .word_valid(rx_valid), .busy(host_busy),
        .burst_done(burst_done));
    udma_sva i_udma_sva(.clk(clk), .rst(rst), .dmarq(bus.dmarq), .dmack_n(bus.dmack_n),
        .stop(bus.stop), .hdmardy_n(bus.hdmardy_n), .addr_idle(bus.addr_idle),
        .dstrobe_oe_n(bus.dstrobe_oe_n), .dstrobe(bus.dstrobe),
        .dd_dev_oe_n(bus.dd_dev_oe_n), .dd_host_oe_n(bus.dd_host_oe_n), .dd(bus.dd));
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    always #20 clk = ~clk;
    assign src_word = src[src_idx % MAXW];
    // word source, can starve the device to force a pause
    always @(posedge bus.link_clk) begin
        took = src_ready === 1'b1;
        #1;
        if (took)
            src_idx++;
        src_valid = !(src_idx == stall_at && stall_len > 0);
        if (!src_valid)
            stall_len--;
    end
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            chk("rx_word", src[rx_idx % MAXW], rx_word);
            rx_idx++;
        end
        if (burst_done === 1'b1)
            n_bursts++;
        #1;
        hold = rx_idx == hold_at && hold_len > 0;
        if (hold)
            hold_len--;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [WORD_W-1:0] exp,
        input logic [WORD_W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic run_burst(input int m, input int n, input int h, input int s, input logic t);
        int k;
        for (k = 0; k < MAXW; k++)
            src[k] = 16'h3C5A ^ WORD_W'(k * 257 + m * 4099 + n);
        src_idx = 0;
        rx_idx = 0;
        n_bursts = 0;
        hold_at = h;
        hold_len = 30;
        stall_at = s;
        stall_len = 12;
        terminate = t;
        @(posedge bus.link_clk);
        #1;
        mode = MODE_W'(m);
        count = WORD_W'(n);
        start = 1'b1;
        for (k = 0; k < 100 && dev_busy !== 1'b1; k++)
            @(posedge bus.link_clk);
        #1;
        start = 1'b0;
        if (enable !== 1'b1) begin
            repeat (40) @(posedge clk);
            #1;
            chk("dmack_n", 16'h0001, {15'h0000, bus.dmack_n});
            chk("dmarq", 16'h0001, {15'h0000, bus.dmarq});
            enable = 1'b1;
        end
        for (k = 0; k < 3000 && dev_done !== 1'b1; k++)
            @(posedge bus.link_clk);
        chk("done", 16'h0001, {15'h0000, dev_done});
        repeat (8) @(posedge clk);
        #1;
        chk("crc_error", 16'h0000, {15'h0000, crc_error});
        // host cut: first word, then up to two more still in flight
        if (t)
            chk("words", 16'h0001, {15'h0000, rx_idx >= 1 && rx_idx <= 3});
        else
            chk("words", WORD_W'(n), WORD_W'(rx_idx));
        chk("bursts", 16'h0001, WORD_W'(n_bursts));
        chk("host_busy", 16'h0000, {15'h0000, host_busy});
        $display("test mode %0d words %0d hold %0d stall %0d end %0d ended", m, n, h, s, t);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    // twenty thousand clocks, several times the longest expected run
    initial begin
        #800000;
        err_count++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int m = 0; m < 4; m++)
            run_burst(m, 4, -1, -1, 1'b0);
        run_burst(2, 6, 2, -1, 1'b0);
        run_burst(1, 5, -1, 2, 1'b0);
        run_burst(0, 6, -1, -1, 1'b1);
        run_burst(2, 1, -1, -1, 1'b0);
        report_and_stop;
    end
endmodule
